//--- rtl/wdg_pkg.sv
package wdg_pkg;
    // register offsets on the plain register port
    localparam logic [3:0]  WDG_OFS_CTRL     = 4'h0;
    localparam logic [3:0]  WDG_OFS_UPPER    = 4'h1;
    localparam logic [3:0]  WDG_OFS_HIGH     = 4'h2;
    localparam logic [3:0]  WDG_OFS_LOW      = 4'h3;

    // watchdog_control_status field positions
    localparam int          WDG_BIT_POR      = 7;
    localparam int          WDG_BIT_STOP     = 6;
    localparam int          WDG_BIT_TMO      = 5;
    localparam int          WDG_BIT_EXT      = 4;
    localparam int          WDG_BIT_HALT_DIS = 0;

    // keyed write values
    localparam logic [7:0]  WDG_KEY_FIRST    = 8'h55;
    localparam logic [7:0]  WDG_KEY_SECOND   = 8'haa;
    localparam logic [7:0]  WDG_HALT_OFF     = 8'h81;
    localparam logic [7:0]  WDG_HALT_ON      = 8'h00;

    // reset values
    localparam logic [23:0] WDG_RELOAD_RST   = 24'hffffff;
    localparam logic        WDG_POR_RST      = 1'b1;
    localparam logic        WDG_HALT_DIS_RST = 1'b0;

    // counter landmarks
    localparam logic [23:0] WDG_CNT_NO_REFRESH = 24'h000002;
    localparam logic [23:0] WDG_CNT_LAST       = 24'h000001;
    localparam logic [23:0] WDG_RELOAD_MIN     = 24'h000004;

    // timeout_response_option level that selects the interrupt response
    localparam logic        WDG_RESP_IRQ     = 1'b1;

    // timing: the oscillator must be sampled several times per period
    localparam int          WDG_SYS_CLK_HZ   = 25000000;
    localparam int          WDG_OSC_NOM_HZ   = 10000;
    localparam int          WDG_SYS_PER_OSC  = WDG_SYS_CLK_HZ / WDG_OSC_NOM_HZ;
    localparam int          WDG_MIN_SYS_PER_OSC = 4;

    typedef enum logic [2:0] {
        UNL_IDLE,
        UNL_FIRST,
        UNL_ARMED,
        UNL_UPPER,
        UNL_HIGH
    } wdg_unlock_t;
endpackage

//--- rtl/wdg_cnt_if.sv
`timescale 1ns/10ps
interface wdg_cnt_if;
    logic        tick;
    logic        enable;
    logic        refresh;
    logic [23:0] reload;
    logic [23:0] count;
    logic        running;
    logic        timeout;

    modport core (input tick, enable, refresh, reload, output count, running, timeout);
    modport ctl  (output tick, enable, refresh, reload, input count, running, timeout);
endinterface

//--- rtl/wdg_counter.sv
`timescale 1ns/10ps
module wdg_counter
    import wdg_pkg::*;
(
    input wire logic   sys_clk,
    input wire logic   rst_n,
    wdg_cnt_if.core    cnt
);
    logic [23:0] count_q;
    logic [23:0] count_d;
    logic        running_q;
    logic        timeout_q;
    logic        start;
    logic        reload_ok;
    logic        expire;

    assign start     = cnt.tick & cnt.enable & ~running_q;
    // refresh is refused from 000002h downward: the time-out is committed
    assign reload_ok = cnt.tick & running_q & cnt.refresh & (count_q > WDG_CNT_NO_REFRESH);
    assign expire    = cnt.tick & running_q & ~reload_ok & (count_q == WDG_CNT_LAST);
    // plain decrement: after 000000h it wraps to all ones, no reload
    assign count_d   = (start | reload_ok) ? cnt.reload :
                       (cnt.tick & running_q) ? count_q - 24'h000001 : count_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q   <= WDG_RELOAD_RST;
            running_q <= 1'b0;
            timeout_q <= 1'b0;
        end else begin
            count_q   <= count_d;
            running_q <= running_q | start;
            timeout_q <= expire;
        end
    end

    assign cnt.count   = count_q;
    assign cnt.running = running_q;
    assign cnt.timeout = timeout_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_no_late_refresh: assert property (
        (cnt.tick && running_q && count_q <= WDG_CNT_NO_REFRESH && count_q != 24'h0)
        |=> count_q == $past(count_q) - 24'h000001)
        else $error("counter reloaded after reaching 2");
    a_timeout_at_zero: assert property (
        timeout_q |-> count_q == 24'h000000)
        else $error("time-out without zero count");
    a_wrap_after_zero: assert property (
        (cnt.tick && running_q && count_q == 24'h0 && !cnt.refresh)
        |=> count_q == 24'hffffff)
        else $error("counter did not wrap to all ones");
    a_start_loads: assert property (
        start |=> running_q && count_q == $past(cnt.reload))
        else $error("first enable did not load reload value");
    c_wrap: cover property (timeout_q ##[1:1000] cnt.tick);
endmodule

//--- rtl/wdg_top.sv
`timescale 1ns/10ps
module wdg_top
    import wdg_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       rc_osc,
    input  wire logic       refresh_instr,
    input  wire logic       always_on_option,
    input  wire logic       timeout_response_option,
    input  wire logic       debug_mode,
    input  wire logic       halt_mode,
    input  wire logic       ext_reset_event,
    input  wire logic       pin_recovery_event,
    output logic            osc_run,
    output logic            wdg_irq,
    output logic            wdg_reset_req,
    output logic            halt_recovery
);
    // the edge detector needs several samples per oscillator period
    if (WDG_SYS_PER_OSC < WDG_MIN_SYS_PER_OSC) begin : g_rate_check
        $error("system clock too slow to sample the RC oscillator");
    end

    wdg_cnt_if cnt ();

    // oscillator pin synchroniser; osc_s2_q and osc_s3_q feed the edge detector
    logic        osc_s1_q;
    logic        osc_s2_q;
    logic        osc_s3_q;
    logic        osc_edge;
    logic        halt_gate;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // reset high: a pin already high at release makes no false edge
            osc_s1_q <= 1'b1;
            osc_s2_q <= 1'b1;
            osc_s3_q <= 1'b1;
        end else begin
            osc_s1_q <= rc_osc;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    logic halt_dis_q;
    logic halt_dis_d;

    assign osc_edge  = osc_s2_q & ~osc_s3_q;
    // halt-disable only matters while halted
    assign halt_gate = halt_mode & halt_dis_q;
    assign osc_run   = ~halt_gate;
    assign cnt.tick  = osc_edge & ~halt_gate;

    // enable: once on, never off
    logic en_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) en_q <= 1'b0;
        else        en_q <= en_q | refresh_instr | always_on_option;
    end
    assign cnt.enable = en_q;

    // refresh held until the next oscillator edge consumes it, so none is lost
    logic refresh_evt;
    logic pend_q;
    logic pend_d;

    assign refresh_evt = refresh_instr | debug_mode;
    assign pend_d      = refresh_evt | (pend_q & ~cnt.tick);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) pend_q <= 1'b0;
        else        pend_q <= pend_d;
    end
    assign cnt.refresh = pend_q | refresh_evt;

    // keyed-write state machine
    wdg_unlock_t unl_q;
    wdg_unlock_t unl_d;
    logic        wr_ctrl;
    logic        wr_upper;
    logic        wr_high;
    logic        wr_low;
    logic        ld_upper;
    logic        ld_high;
    logic        ld_low;
    logic        ld_halt;

    assign wr_ctrl  = reg_wr & (reg_addr == WDG_OFS_CTRL);
    assign wr_upper = reg_wr & (reg_addr == WDG_OFS_UPPER);
    assign wr_high  = reg_wr & (reg_addr == WDG_OFS_HIGH);
    assign wr_low   = reg_wr & (reg_addr == WDG_OFS_LOW);
    assign ld_upper = wr_upper & (unl_q == UNL_ARMED);
    assign ld_high  = wr_high & (unl_q == UNL_UPPER);
    assign ld_low   = wr_low & (unl_q == UNL_HIGH);
    assign ld_halt  = wr_ctrl & (unl_q == UNL_ARMED) &
                      ((reg_wdata == WDG_HALT_OFF) | (reg_wdata == WDG_HALT_ON));
    assign halt_dis_d = ld_halt ? (reg_wdata == WDG_HALT_OFF) : halt_dis_q;

    always_comb begin
        unl_d = unl_q;
        if (reg_wr) begin
            // any write that does not continue the sequence drops it
            unl_d = UNL_IDLE;
            unique case (unl_q)
                UNL_IDLE: begin
                    if (wr_ctrl && reg_wdata == WDG_KEY_FIRST) unl_d = UNL_FIRST;
                end
                UNL_FIRST: begin
                    if (wr_ctrl && reg_wdata == WDG_KEY_SECOND) unl_d = UNL_ARMED;
                end
                UNL_ARMED: begin
                    if (ld_upper) unl_d = UNL_UPPER;
                end
                UNL_UPPER: begin
                    if (ld_high) unl_d = UNL_HIGH;
                end
                UNL_HIGH: begin
                    unl_d = UNL_IDLE;
                end
            endcase
        end
    end

    logic [23:0] reload_q;
    logic [23:0] reload_d;

    assign reload_d = {ld_upper ? reg_wdata : reload_q[23:16],
                       ld_high  ? reg_wdata : reload_q[15:8],
                       ld_low   ? reg_wdata : reload_q[7:0]};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            unl_q      <= UNL_IDLE;
            reload_q   <= WDG_RELOAD_RST;
            halt_dis_q <= WDG_HALT_DIS_RST;
        end else begin
            unl_q      <= unl_d;
            reload_q   <= reload_d;
            halt_dis_q <= halt_dis_d;
        end
    end
    assign cnt.reload = reload_q;

    wdg_counter u_counter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cnt     (cnt)
    );

    // time-out response, already on sys_clk
    logic tmo;
    logic irq_mode;
    logic irq_q;
    logic rst_req_q;
    logic recov_q;

    assign tmo      = cnt.timeout;
    assign irq_mode = (timeout_response_option == WDG_RESP_IRQ);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q     <= 1'b0;
            rst_req_q <= 1'b0;
            recov_q   <= 1'b0;
        end else begin
            irq_q     <= tmo & irq_mode;
            rst_req_q <= tmo & ~irq_mode & ~halt_mode;
            recov_q   <= tmo & halt_mode;
        end
    end
    assign wdg_irq       = irq_q;
    assign wdg_reset_req = rst_req_q;
    assign halt_recovery = recov_q;

    // status flags: a set in the same cycle as a clear wins
    logic rd_ctrl;
    logic stop_evt;
    logic por_q;
    logic stop_q;
    logic tmo_q;
    logic ext_q;
    logic por_d;
    logic stop_d;
    logic tmo_d;
    logic ext_d;

    assign rd_ctrl  = reg_rd & (reg_addr == WDG_OFS_CTRL);
    assign stop_evt = (tmo & halt_mode) | pin_recovery_event;
    assign por_d    = por_q & ~(tmo | stop_evt | rd_ctrl);
    assign stop_d   = stop_evt | (stop_q & ~(rd_ctrl | (tmo & ~halt_mode)));
    assign tmo_d    = tmo | (tmo_q & ~(rd_ctrl | pin_recovery_event));
    assign ext_d    = ext_reset_event | (ext_q & ~(rd_ctrl | pin_recovery_event));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_q  <= WDG_POR_RST;
            stop_q <= 1'b0;
            tmo_q  <= 1'b0;
            ext_q  <= 1'b0;
        end else begin
            por_q  <= por_d;
            stop_q <= stop_d;
            tmo_q  <= tmo_d;
            ext_q  <= ext_d;
        end
    end

    // read path: one cycle latency, unmapped offsets read zero
    logic [7:0] ctrl_view;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    always_comb begin
        ctrl_view                   = 8'h00;
        ctrl_view[WDG_BIT_POR]      = por_q;
        ctrl_view[WDG_BIT_STOP]     = stop_q;
        ctrl_view[WDG_BIT_TMO]      = tmo_q;
        ctrl_view[WDG_BIT_EXT]      = ext_q;
        ctrl_view[WDG_BIT_HALT_DIS] = halt_dis_q;
    end

    assign rdata_d = !reg_rd                       ? 8'h00 :
                     (reg_addr == WDG_OFS_CTRL)    ? ctrl_view :
                     (reg_addr == WDG_OFS_UPPER)   ? cnt.count[23:16] :
                     (reg_addr == WDG_OFS_HIGH)    ? cnt.count[15:8] :
                     (reg_addr == WDG_OFS_LOW)     ? cnt.count[7:0] : 8'h00;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rdata_q <= 8'h00;
        else        rdata_q <= rdata_d;
    end
    assign reg_rdata = rdata_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_tick_from_osc: assert property (
        cnt.tick |-> $past(osc_s2_q, 1) == 1'b0 && osc_s2_q)
        else $error("tick without oscillator edge");
    a_enable_sticky: assert property (
        (refresh_instr || always_on_option) |=> en_q ##1 en_q)
        else $error("enable not taken or dropped");
    a_debug_reload: assert property (
        (debug_mode && cnt.tick && cnt.running && cnt.count > WDG_CNT_NO_REFRESH)
        |=> cnt.count == $past(cnt.reload))
        else $error("debug tick did not reload the counter");
    a_irq_response: assert property (
        (tmo && irq_mode) |=> wdg_irq && !wdg_reset_req && tmo_q)
        else $error("interrupt response wrong");
    a_reset_response: assert property (
        (tmo && !irq_mode && !halt_mode) |=> wdg_reset_req && !wdg_irq && tmo_q)
        else $error("reset response wrong");
    a_halt_recovery: assert property (
        (tmo && halt_mode) |=> halt_recovery && stop_q && tmo_q)
        else $error("halt recovery flags wrong");
    a_halt_gate: assert property (
        (halt_mode && halt_dis_q) |-> !cnt.tick && !osc_run ##1 $stable(cnt.count))
        else $error("tick while disabled in halt");
    a_halt_key: assert property (
        (wr_ctrl && unl_q == UNL_ARMED && reg_wdata == WDG_HALT_OFF) |=> halt_dis_q)
        else $error("halt disable key not applied");
    a_reload_locked: assert property (
        (wr_upper && unl_q != UNL_ARMED) |=> reload_q[23:16] == $past(reload_q[23:16]))
        else $error("reload byte written while locked");
    a_read_live: assert property (
        (reg_rd && reg_addr == WDG_OFS_LOW) |=> reg_rdata == $past(cnt.count[7:0]))
        else $error("reload read not live count");
    a_read_clears: assert property (
        (rd_ctrl && !tmo && !stop_evt && !ext_reset_event)
        |=> !por_q && !stop_q && !tmo_q && !ext_q)
        else $error("status read did not clear flags");
    a_ext_flag: assert property (
        ext_reset_event |=> ext_q)
        else $error("external reset flag not set");

    // register port and unlock sequence
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (
        (reg_rd && reg_addr > WDG_OFS_LOW) |=> reg_rdata == 8'h00)
        else $error("unmapped offset read not zero");
    a_unlock_abort: assert property (
        (reg_wr && !wr_ctrl && (unl_q == UNL_IDLE || unl_q == UNL_FIRST)) |=> unl_q == UNL_IDLE)
        else $error("stray write did not drop the unlock");
    a_low_completes: assert property (
        ld_low |=> unl_q == UNL_IDLE && reload_q[7:0] == $past(reg_wdata))
        else $error("low reload byte not taken");
    a_halt_on_key: assert property (
        (wr_ctrl && unl_q == UNL_ARMED && reg_wdata == WDG_HALT_ON) |=> !halt_dis_q)
        else $error("halt enable key not applied");

    // refresh hand-over, enable and responses
    a_refresh_held: assert property (
        (pend_q && !cnt.tick) |=> pend_q)
        else $error("pending refresh lost before a tick");
    a_refresh_consumed: assert property (
        (cnt.tick && !refresh_evt) |=> !pend_q)
        else $error("refresh applied twice");
    a_enable_needed: assert property (
        !en_q |-> !cnt.running)
        else $error("counter running while not enabled");
    a_osc_default: assert property (
        !halt_mode |-> osc_run)
        else $error("oscillator stopped outside halt");
    a_irq_single: assert property (
        wdg_irq |=> !wdg_irq)
        else $error("interrupt request longer than one cycle");
    a_reset_quiet_halt: assert property (
        (tmo && halt_mode) |=> !wdg_reset_req)
        else $error("device reset requested while halted");

    c_irq_timeout: cover property (tmo && irq_mode);
    c_reset_timeout: cover property (tmo && !irq_mode);
    c_full_unlock: cover property (ld_upper ##1 ld_high ##1 ld_low);
    c_halt_wake: cover property (recov_q);
endmodule

//--- sim/wdg_far_model.sv
`timescale 1ns/10ps
module wdg_far_model (
    input  wire logic sys_clk,
    input  wire logic osc_run,
    input  wire logic wdg_irq,
    input  wire logic wdg_reset_req,
    input  wire logic halt_recovery,
    output logic      rc_osc,
    output int        n_edge,
    output int        n_irq,
    output int        n_rst,
    output int        n_rec
);
    // own oscillator, phase unrelated to sys_clk; sped up so runs stay short
    initial begin
        rc_osc = 1'b0;
        forever begin
            #415 rc_osc = (osc_run === 1'b0) ? 1'b0 : ~rc_osc;
        end
    end
    initial begin
        n_edge = 0;
        n_irq = 0;
        n_rst = 0;
        n_rec = 0;
    end
    always @(posedge rc_osc) begin
        n_edge <= n_edge + 1;
    end
    // interrupt controller, reset logic and halt wake simply count requests
    always @(posedge sys_clk) begin
        n_irq <= n_irq + int'(wdg_irq === 1'b1);
        n_rst <= n_rst + int'(wdg_reset_req === 1'b1);
        n_rec <= n_rec + int'(halt_recovery === 1'b1);
    end
endmodule

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
    import wdg_pkg::*;
    logic        sys_clk, rst_n, reg_wr, reg_rd, rc_osc, refresh_instr;
    logic        always_on_option, timeout_response_option, debug_mode, halt_mode;
    logic        ext_reset_event, pin_recovery_event, osc_run, wdg_irq, wdg_reset_req;
    logic        halt_recovery;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [31:0] seed;
    int          mismatches, n_tests, n_edge, n_irq, n_rst, n_rec, r, e0, i0, k;

    wdg_top wdg_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rc_osc(rc_osc), .refresh_instr(refresh_instr), .always_on_option(always_on_option),
        .timeout_response_option(timeout_response_option), .debug_mode(debug_mode),
        .halt_mode(halt_mode), .ext_reset_event(ext_reset_event),
        .pin_recovery_event(pin_recovery_event), .osc_run(osc_run), .wdg_irq(wdg_irq),
        .wdg_reset_req(wdg_reset_req), .halt_recovery(halt_recovery));
    wdg_far_model wdg_far_model_inst (.sys_clk(sys_clk), .osc_run(osc_run),
        .wdg_irq(wdg_irq), .wdg_reset_req(wdg_reset_req), .halt_recovery(halt_recovery),
        .rc_osc(rc_osc), .n_edge(n_edge), .n_irq(n_irq), .n_rst(n_rst), .n_rec(n_rec));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // first enable or refresh: one tick loads, then reload ticks down to zero
    function automatic int edges_to_timeout(input int rl);
        return rl + 1;
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand in the cycle after the strobe, taken at the edge ending it
    task automatic rd8(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        rd8(a);
        chk({24'h0, d}, {24'h0, e});
    endtask
    task automatic set_reload(input logic [23:0] v);
        wr(WDG_OFS_CTRL, WDG_KEY_FIRST);
        wr(WDG_OFS_CTRL, WDG_KEY_SECOND);
        wr(WDG_OFS_UPPER, v[23:16]);
        wr(WDG_OFS_HIGH, v[15:8]);
        wr(WDG_OFS_LOW, v[7:0]);
    endtask
    // just after a pin edge, so its tick has landed
    task automatic after_tick();
        @(posedge rc_osc);
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic pulse_ref();
        after_tick();
        refresh_instr <= 1'b1;
        @(posedge sys_clk);
        refresh_instr <= 1'b0;
    endtask
    task automatic wait_evt(input int lim);
        int t0;
        int n;
        t0 = n_irq + n_rst + n_rec;
        n = 0;
        while (n_irq + n_rst + n_rec == t0 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic span(input int ee, input int ei, input int er, input int eh, input int lim);
        int a0;
        int b0;
        int c0;
        pulse_ref();
        e0 = n_edge;
        a0 = n_irq;
        b0 = n_rst;
        c0 = n_rec;
        wait_evt(lim);
        if (ee != 0) chk(n_edge - e0, ee);
        chk(n_irq - a0, ei);
        chk(n_rst - b0, er);
        chk(n_rec - c0, eh);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end
    initial begin
        mismatches = 0;
        n_tests = 0;
        seed = 32'd43;
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        refresh_instr = 1'b0;
        always_on_option = 1'b0;
        timeout_response_option = WDG_RESP_IRQ;
        debug_mode = 1'b0;
        halt_mode = 1'b0;
        ext_reset_event = 1'b0;
        pin_recovery_event = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk(WDG_OFS_CTRL, 8'h80);
        rchk(WDG_OFS_CTRL, 8'h00);
        rchk(4'(4 + rnd() % 12), 8'h00);
        repeat (4) @(posedge rc_osc);
        rchk(WDG_OFS_LOW, 8'hff);
        note("reset");
        set_reload(24'h000004);
        wr(WDG_OFS_LOW, 8'h01);
        wr(WDG_OFS_CTRL, WDG_KEY_FIRST);
        wr(WDG_OFS_CTRL, WDG_KEY_SECOND);
        wr(WDG_OFS_UPPER, 8'h00);
        wr(4'(4 + rnd() % 12), 8'h00);
        wr(WDG_OFS_HIGH, 8'h00);
        wr(WDG_OFS_LOW, 8'h01);
        span(edges_to_timeout(4), 1, 0, 0, 2000);
        // the wrap shows only after the tick that follows zero
        after_tick();
        rchk(WDG_OFS_UPPER, 8'hff);
        rchk(WDG_OFS_HIGH, 8'hff);
        rchk(WDG_OFS_CTRL, 8'h20);
        pulse_ref();
        // the refresh of span then lands at count three, just above the cut-off
        @(posedge rc_osc);
        span(edges_to_timeout(4), 1, 0, 0, 2000);
        note("enable");
        // a refresh that arrives once the count is at two is ignored
        pulse_ref();
        k = 0;
        rd8(WDG_OFS_LOW);
        while (d !== 8'h02 && k < 500) begin
            rd8(WDG_OFS_LOW);
            k++;
        end
        chk({24'h0, d}, 32'h00000002);
        @(posedge sys_clk);
        e0 = n_edge;
        refresh_instr <= 1'b1;
        @(posedge sys_clk);
        refresh_instr <= 1'b0;
        wait_evt(2000);
        chk(n_edge - e0, 2);
        note("late refresh");
        r = 4 + int'(rnd() % 9);
        set_reload(24'(r));
        timeout_response_option <= ~WDG_RESP_IRQ;
        span(edges_to_timeout(r), 0, 1, 0, 2000);
        rchk(WDG_OFS_CTRL, 8'h20);
        halt_mode <= 1'b1;
        span(edges_to_timeout(r), 0, 0, 1, 2000);
        rchk(WDG_OFS_CTRL, 8'h60);
        timeout_response_option <= WDG_RESP_IRQ;
        span(edges_to_timeout(r), 1, 0, 1, 2000);
        rchk(WDG_OFS_CTRL, 8'h60);
        halt_mode <= 1'b0;
        note("responses");
        set_reload(24'(r));
        wr(WDG_OFS_CTRL, WDG_KEY_FIRST);
        wr(WDG_OFS_CTRL, WDG_KEY_SECOND);
        wr(WDG_OFS_CTRL, WDG_HALT_OFF);
        rchk(WDG_OFS_CTRL, 8'h01);
        pulse_ref();
        halt_mode <= 1'b1;
        e0 = n_edge;
        i0 = n_irq + n_rst + n_rec;
        wait_evt(800);
        chk(osc_run, 1'b0);
        chk(n_edge - e0 + n_irq + n_rst + n_rec - i0, 0);
        halt_mode <= 1'b0;
        span(edges_to_timeout(r), 1, 0, 0, 2000);
        chk(osc_run, 1'b1);
        rchk(WDG_OFS_CTRL, 8'h21);
        wr(WDG_OFS_CTRL, WDG_KEY_FIRST);
        wr(WDG_OFS_CTRL, WDG_KEY_SECOND);
        wr(WDG_OFS_CTRL, WDG_HALT_ON);
        rchk(WDG_OFS_CTRL, 8'h00);
        note("halt disable");
        debug_mode <= 1'b1;
        span(0, 0, 0, 0, 1000);
        debug_mode <= 1'b0;
        @(posedge sys_clk);
        ext_reset_event <= 1'b1;
        @(posedge sys_clk);
        ext_reset_event <= 1'b0;
        pin_recovery_event <= 1'b1;
        @(posedge sys_clk);
        pin_recovery_event <= 1'b0;
        rchk(WDG_OFS_CTRL, 8'h40);
        @(posedge sys_clk);
        ext_reset_event <= 1'b1;
        @(posedge sys_clk);
        ext_reset_event <= 1'b0;
        rchk(WDG_OFS_CTRL, 8'h10);
        note("debug and flags");
        // second reset in mid-run, enabled by the option level alone
        always_on_option <= 1'b1;
        rst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        @(posedge rc_osc);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge rc_osc);
        repeat (5) @(posedge sys_clk);
        rchk(WDG_OFS_LOW, 8'hfc);
        rchk(WDG_OFS_UPPER, 8'hff);
        note("always on");
        test_done();
    end
endmodule
